/* hdl/sidc_top.sv */
/*
 Register bank of the switch engine ingress configuration: VLAN command
 status, indirect access to the 64-entry ToS/CS priority table, and the
 global ingress configuration, over an AXI4-Lite slave.
 Assumes vlan_cmd_busy_i and lookup_index_i come from logic on core_clk_i.
*/
`timescale 1ns/1ps
module sidc_top (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [15:0] s_axi_awaddr_i,
   input wire logic [2:0] s_axi_awprot_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   output logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   input wire logic [15:0] s_axi_araddr_i,
   input wire logic [2:0] s_axi_arprot_i,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   input wire logic vlan_cmd_busy_i,
   input wire logic [5:0] lookup_index_i,
   output logic [2:0] lookup_priority_o,
   output sidc_pkg::sidc_gcfg_s gcfg_o,
   output logic [31:0] counter_read_value_o,
   output logic tbl_pending_o
);
   sidc_pkg::sidc_state_s state_reg;
   sidc_pkg::sidc_state_s state_next;
   logic [2:0] tbl_mem [0:63];
   logic tbl_we;

   function automatic logic [31:0] merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] strb
   );
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   function automatic logic is_mapped(input logic [13:0] idx);
      return idx == sidc_pkg::IDX_VLAN_STS || idx == sidc_pkg::IDX_TBL_CMD ||
         idx == sidc_pkg::IDX_TBL_WDATA || idx == sidc_pkg::IDX_TBL_RDATA ||
         idx == sidc_pkg::IDX_TBL_STS || idx == sidc_pkg::IDX_GCFG;
   endfunction : is_mapped

   assign s_axi_awready_o = !state_reg.aw_held && !state_reg.bvalid;
   assign s_axi_wready_o = !state_reg.w_held && !state_reg.bvalid;
   assign s_axi_arready_o = !state_reg.rvalid;
   assign s_axi_bvalid_o = state_reg.bvalid;
   assign s_axi_bresp_o = state_reg.bresp;
   assign s_axi_rvalid_o = state_reg.rvalid;
   assign s_axi_rdata_o = state_reg.rdata;
   assign s_axi_rresp_o = state_reg.rresp;
   assign lookup_priority_o = state_reg.lookup_prio;
   assign tbl_pending_o = state_reg.pend;

   always_comb begin
      logic [13:0] widx;
      logic [13:0] ridx;
      logic [31:0] merged;
      widx = state_reg.awaddr[15:2];
      ridx = s_axi_araddr_i[15:2];
      merged = 32'h0000_0000;
      state_next = state_reg;
      tbl_we = 1'b0;

      if (state_reg.bvalid && s_axi_bready_i) begin
         state_next.bvalid = 1'b0;
      end
      if (state_reg.rvalid && s_axi_rready_i) begin
         state_next.rvalid = 1'b0;
      end
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         state_next.aw_held = 1'b1;
         state_next.awaddr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         state_next.w_held = 1'b1;
         state_next.wdata = s_axi_wdata_i;
         state_next.wstrb = s_axi_wstrb_i;
      end

      // Table access sequencer
      unique case (state_reg.tstate)
         sidc_pkg::TS_IDLE: begin
         end
         sidc_pkg::TS_BUSY: begin
            if (state_reg.cnt == 2'h0) begin
               if (state_reg.cmd[sidc_pkg::CMD_DIR_BIT]) begin // RL3
                  state_next.rd_prio = tbl_mem[state_reg.cmd[5:0]]; // RL4 RL5
               end else begin
                  tbl_we = 1'b1; // RL3
               end
               state_next.pend = 1'b0; // RL9
               state_next.tstate = sidc_pkg::TS_IDLE;
            end else begin
               state_next.cnt = state_reg.cnt - 2'h1;
            end
         end
      endcase

      // Write commit once address and data are both held
      if (state_reg.aw_held && state_reg.w_held) begin
         state_next.aw_held = 1'b0;
         state_next.w_held = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = is_mapped(widx) ? sidc_pkg::RESP_OKAY :
            sidc_pkg::RESP_SLVERR;
         if (widx == sidc_pkg::IDX_TBL_CMD) begin
            merged = merge({24'h00_0000, state_reg.cmd}, state_reg.wdata,
               state_reg.wstrb);
            // A command written while busy is dropped
            if (!state_reg.pend && state_reg.wstrb[0]) begin // RL22
               state_next.cmd = merged[7:0] & sidc_pkg::CMD_MASK;
               state_next.pend = 1'b1; // RL2 RL9
               state_next.tstate = sidc_pkg::TS_BUSY; // RL2
               state_next.cnt = sidc_pkg::TBL_ACCESS_CYCLES - 2'h1;
            end
         end
         if (widx == sidc_pkg::IDX_TBL_WDATA && !state_reg.pend &&
               state_reg.wstrb[0]) begin
            state_next.wr_prio = state_reg.wdata[2:0]; // RL6 RL7
         end
         if (widx == sidc_pkg::IDX_GCFG) begin
            merged = merge({16'h0000, state_reg.gcfg}, state_reg.wdata,
               state_reg.wstrb);
            state_next.gcfg = merged[15:0];
         end
      end

      if (s_axi_arvalid_i && s_axi_arready_o) begin
         state_next.rvalid = 1'b1;
         state_next.rresp = is_mapped(ridx) ? sidc_pkg::RESP_OKAY :
            sidc_pkg::RESP_SLVERR;
         state_next.rdata = 32'h0000_0000;
         if (ridx == sidc_pkg::IDX_VLAN_STS) begin
            state_next.rdata[0] = vlan_cmd_busy_i; // RL1
         end
         if (ridx == sidc_pkg::IDX_TBL_CMD) begin
            state_next.rdata[7:0] = state_reg.cmd;
         end
         if (ridx == sidc_pkg::IDX_TBL_WDATA) begin
            state_next.rdata[2:0] = state_reg.wr_prio;
         end
         if (ridx == sidc_pkg::IDX_TBL_RDATA) begin
            state_next.rdata[2:0] = state_reg.rd_prio; // RL5
         end
         if (ridx == sidc_pkg::IDX_TBL_STS) begin
            state_next.rdata[0] = state_reg.pend; // RL9
         end
         if (ridx == sidc_pkg::IDX_GCFG) begin
            state_next.rdata[15:0] = state_reg.gcfg;
         end
      end

      // Datapath lookup of the receive priority by ToS/CS value
      state_next.lookup_prio = tbl_mem[lookup_index_i]; // RL7
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg.aw_held <= 1'b0;
         state_reg.awaddr <= 16'h0000;
         state_reg.w_held <= 1'b0;
         state_reg.wdata <= 32'h0000_0000;
         state_reg.wstrb <= 4'h0;
         state_reg.bvalid <= 1'b0;
         state_reg.bresp <= sidc_pkg::RESP_OKAY;
         state_reg.rvalid <= 1'b0;
         state_reg.rdata <= 32'h0000_0000;
         state_reg.rresp <= sidc_pkg::RESP_OKAY;
         state_reg.cmd <= sidc_pkg::CMD_RESET;
         state_reg.wr_prio <= sidc_pkg::PRIO_RESET;
         state_reg.rd_prio <= sidc_pkg::PRIO_RESET;
         state_reg.pend <= 1'b0;
         state_reg.tstate <= sidc_pkg::TS_IDLE;
         state_reg.cnt <= 2'h0;
         state_reg.gcfg <= sidc_pkg::GCFG_RESET; // RL19 RL20 RL21
         state_reg.lookup_prio <= sidc_pkg::PRIO_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // Table contents keep no reset value
   always_ff @(posedge core_clk_i) begin
      if (tbl_we) begin
         tbl_mem[state_reg.cmd[5:0]] <= state_reg.wr_prio; // RL4 RL7 RL8
      end
   end

   always_comb begin
      gcfg_o.vlan_id_ignore =
         state_reg.gcfg[sidc_pkg::GC_VLAN_ID_IGNORE]; // RL10
      gcfg_o.use_tag_prio = state_reg.gcfg[sidc_pkg::GC_USE_TAG]; // RL11
      gcfg_o.allow_monitor_echo =
         state_reg.gcfg[sidc_pkg::GC_MON_ECHO]; // RL12
      gcfg_o.igmp_port_map =
         state_reg.gcfg[sidc_pkg::GC_IGMP_MAP_LO +: 3]; // RL13
      gcfg_o.use_ip_prio = state_reg.gcfg[sidc_pkg::GC_USE_IP]; // RL14
      gcfg_o.igmp_monitor_en = state_reg.gcfg[sidc_pkg::GC_IGMP_EN]; // RL13
      gcfg_o.counter_test = state_reg.gcfg[sidc_pkg::GC_CNT_TEST]; // RL15
      gcfg_o.da_prio_en = state_reg.gcfg[sidc_pkg::GC_DA_PRIO]; // RL16
      // Broadcasts must be excluded by the filter user
      gcfg_o.filter_unknown_mcast =
         state_reg.gcfg[sidc_pkg::GC_FILT_MCAST]; // RL17
      gcfg_o.drop_unknown_ucast =
         state_reg.gcfg[sidc_pkg::GC_DROP_UCAST]; // RL18
      gcfg_o.use_precedence = state_reg.gcfg[sidc_pkg::GC_USE_PREC]; // RL19
      gcfg_o.tag_over_ip = state_reg.gcfg[sidc_pkg::GC_TAG_OVER_IP]; // RL20
      gcfg_o.vlan_en = state_reg.gcfg[sidc_pkg::GC_VLAN_EN]; // RL21
      counter_read_value_o = state_reg.gcfg[sidc_pkg::GC_CNT_TEST] ?
         sidc_pkg::COUNTER_TEST_VALUE : sidc_pkg::COUNTER_CLEAR_VALUE; // RL15
   end
endmodule : sidc_top

/* hdl/sidc_pkg.sv */
/*
 Constants, register map and carrier types of the ingress and priority
 table configuration block of a small switch engine.
 Assumes one 250 MHz clock and an AXI4-Lite master with 32-bit data.
*/
// Function
// (RL1) VLAN pending flag bit 0 reads one while a VLAN table command runs.
// (RL2) Writing the table command register launches one table access.
// (RL3) Command bit 7 selects direction: one reads, zero writes.
// (RL4) Command bits 5:0 select the table entry accessed.
// (RL5) After pending clears, read data register shows the selected entry.
// (RL6) Software loads write data before writing a write command, then polls.
// (RL7) Each entry holds a 3-bit priority for packets matching its index.
// (RL8) Table is not reset; software programs all entries after power-up.
// (RL9) Table pending flag bit 0 sets on a command and self-clears when done.
// (RL10) Global bit 15 ignores tag VLAN identifier, uses port default one.
// (RL11) Global bit 14 allows tag priority as transmit queue source.
// (RL12) Global bit 13 allows monitored packets back to their source port.
// (RL13) Global bit 7 enables IGMP monitoring to port bitmap bits 12:10.
// (RL14) Global bit 9 allows IP ToS or class as transmit queue source.
// (RL15) Global bit 6 makes clear-on-read counters load 7FFF_FFFCh on read.
// (RL16) Global bit 5 takes queue from lookup entry priority when enabled.
// (RL17) Global bit 4 drops unknown multicast, broadcast exempt.
// (RL18) Global bit 3 drops unicast with unknown destination.
// (RL19) Global bit 2 picks IPv4 precedence bits or table; resets to one.
// (RL20) Global bit 1 gives tag priority precedence over IP; resets to one.
// (RL21) Global bit 0 enables VLAN ingress rules; resets to zero.
// (RL22) Software leaves command and write data alone while pending.
package sidc_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [13:0] IDX_VLAN_STS = 14'h1810;
   localparam logic [13:0] IDX_TBL_CMD = 14'h1811;
   localparam logic [13:0] IDX_TBL_WDATA = 14'h1812;
   localparam logic [13:0] IDX_TBL_RDATA = 14'h1813;
   localparam logic [13:0] IDX_TBL_STS = 14'h1814;
   localparam logic [13:0] IDX_GCFG = 14'h1840;
   localparam int ADDR_W = 16;

   localparam int CMD_DIR_BIT = 7;
   localparam logic [7:0] CMD_MASK = 8'hBF;
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [2:0] PRIO_RESET = 3'h0;
   localparam logic [15:0] GCFG_RESET = 16'h0006;

   localparam int GC_VLAN_ID_IGNORE = 15;
   localparam int GC_USE_TAG = 14;
   localparam int GC_MON_ECHO = 13;
   localparam int GC_IGMP_MAP_LO = 10;
   localparam int GC_USE_IP = 9;
   localparam int GC_IGMP_EN = 7;
   localparam int GC_CNT_TEST = 6;
   localparam int GC_DA_PRIO = 5;
   localparam int GC_FILT_MCAST = 4;
   localparam int GC_DROP_UCAST = 3;
   localparam int GC_USE_PREC = 2;
   localparam int GC_TAG_OVER_IP = 1;
   localparam int GC_VLAN_EN = 0;

   localparam logic [31:0] COUNTER_TEST_VALUE = 32'h7FFF_FFFC;
   localparam logic [31:0] COUNTER_CLEAR_VALUE = 32'h0000_0000;

   // Table access time in clock cycles at 250 MHz
   localparam logic [1:0] TBL_ACCESS_CYCLES = 2'h2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      TS_IDLE = 2'b01,
      TS_BUSY = 2'b10
   } sidc_tstate_e;

   typedef struct packed {
      logic vlan_id_ignore;
      logic use_tag_prio;
      logic allow_monitor_echo;
      logic [2:0] igmp_port_map;
      logic use_ip_prio;
      logic igmp_monitor_en;
      logic counter_test;
      logic da_prio_en;
      logic filter_unknown_mcast;
      logic drop_unknown_ucast;
      logic use_precedence;
      logic tag_over_ip;
      logic vlan_en;
   } sidc_gcfg_s;

   typedef struct packed {
      logic aw_held;
      logic [ADDR_W-1:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] cmd;
      logic [2:0] wr_prio;
      logic [2:0] rd_prio;
      logic pend;
      sidc_tstate_e tstate;
      logic [1:0] cnt;
      logic [15:0] gcfg;
      logic [2:0] lookup_prio;
   } sidc_state_s;
endpackage : sidc_pkg

/* verification/sidc_top_asserts.sv */
/* Port assertions for sidc_top, bound to every instance below.
 Assumes one clock and the active-low asynchronous reset. */
`timescale 1ns/1ps
module sidc_top_asserts (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rvalid_o,
   input wire sidc_pkg::sidc_gcfg_s gcfg_o,
   input wire logic [31:0] counter_read_value_o,
   input wire logic tbl_pending_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   property p_pend_len;
      $rose(tbl_pending_o) |-> tbl_pending_o[*2] ##1 !tbl_pending_o; endproperty
   a_pend_len: assert property (p_pend_len) else $error("pend len");
   property p_pend_cause;
      $rose(tbl_pending_o) |-> $rose(s_axi_bvalid_o); endproperty
   a_pend_cause: assert property (p_pend_cause) else $error("stray");
   property p_cfg_cause;
      $changed(gcfg_o) |-> $rose(s_axi_bvalid_o); endproperty
   a_cfg_cause: assert property (p_cfg_cause) else $error("cfg chg");
   property p_cnt; counter_read_value_o == (gcfg_o.counter_test ?
      sidc_pkg::COUNTER_TEST_VALUE : sidc_pkg::COUNTER_CLEAR_VALUE);
   endproperty
   a_cnt: assert property (p_cnt) else $error("counter read value");
   property p_wr_ans; s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
      s_axi_wready_o |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o; endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write answer");
   property p_rd_ans;
      s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read answer");
   property p_ar_block; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
   a_ar_block: assert property (p_ar_block) else $error("ar taken");
   property p_aw_block;
      s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
   a_aw_block: assert property (p_aw_block) else $error("aw taken");
endmodule : sidc_top_asserts

bind sidc_top sidc_top_asserts chk_u (.core_clk_i(core_clk_i),
   .nrst_i(nrst_i), .s_axi_awvalid_i(s_axi_awvalid_i),
   .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rvalid_o(s_axi_rvalid_o), .gcfg_o(gcfg_o),
   .counter_read_value_o(counter_read_value_o), .tbl_pending_o(tbl_pending_o));

/* verification/tb.sv */
/* Self-checking bench for sidc_top over AXI4-Lite.
 Assumes the package, design and checker are compiled first. */
`timescale 1ns/1ps
module tb;
   logic clk = 0, nrst = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic awr, wr, bv, arr, rv, pend, busy = 0;
   logic [15:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd, crv, d;
   logic [3:0] ws = 0;
   logic [2:0] awp = 0, arp = 0, lpri;
   logic [2:0] pr [64];
   logic [1:0] bresp, rresp, r;
   logic [5:0] lidx = 0;
   sidc_pkg::sidc_gcfg_s gcfg;
   int mismatches = 0, compares = 0, cyc = 0;
   localparam logic [15:0] A_VS = 16'h6040, A_CMD = 16'h6044, A_WD = 16'h6048;
   localparam logic [15:0] A_RD = 16'h604C, A_ST = 16'h6050, A_GC = 16'h6100;
   initial forever #2 clk = ~clk;
   sidc_top dut_u (.core_clk_i(clk), .nrst_i(nrst), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_awprot_i(awp),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_wdata_i(wd),
      .s_axi_wstrb_i(ws), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
      .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_araddr_i(ara), .s_axi_arprot_i(arp), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(rr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp),
      .vlan_cmd_busy_i(busy), .lookup_index_i(lidx),
      .lookup_priority_o(lpri), .gcfg_o(gcfg), .counter_read_value_o(crv),
      .tbl_pending_o(pend));
   task automatic chk(input string n, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   function automatic logic [31:0] gexp(input logic [31:0] v);
      return {17'h0, v[15:9], v[7:0]};
   endfunction : gexp
   task automatic axw(input logic [15:0] a, input logic [31:0] v,
      input logic [3:0] s, output logic [1:0] q);
      awa <= a;
      wd <= v;
      ws <= s;
      awp <= 3'($urandom);
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      forever begin
         @(posedge clk);
         if (bv) begin
            q = bresp;
            break;
         end
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end
   endtask : axw
   task automatic axr(input logic [15:0] a, output logic [31:0] v,
      output logic [1:0] q);
      ara <= a;
      arp <= 3'($urandom);
      arv <= 1'b1;
      rr <= 1'b1;
      forever begin
         @(posedge clk);
         if (rv) begin
            v = rd;
            q = rresp;
            break;
         end
         if (arr) arv <= 1'b0;
      end
   endtask : axr
   task automatic poll();
      logic [31:0] s;
      logic [1:0] q;
      do axr(A_ST, s, q);
      while (s[0] !== 1'b0);
   endtask : poll
   task summarize();
      if (mismatches == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         summarize();
      end
   end
   initial begin
      int i;
      logic [31:0] v;
      void'($urandom(91427));
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk("gcfg_o", gcfg, 32'h6);
      chk("count", crv, 32'h0);
      axr(A_GC, d, r);
      chk("gcfg_rd", d, 32'h6);
      for (i = 0; i < 20; i++) begin
         v = (i < 16) ? 32'h1 << i : $urandom;
         axw(A_GC, v, 4'hF, r);
         chk("bresp_ok", r, sidc_pkg::RESP_OKAY);
         axr(A_GC, d, r);
         chk("gcfg_rd", d, {16'h0, v[15:0]});
         chk("gcfg_o", gcfg, gexp(v));
         chk("count", crv, v[6] ? 32'h7FFF_FFFC : 32'h0);
      end
      axw(A_GC, ~v, 4'h0, r);
      chk("gcfg_o", gcfg, gexp(v));
      for (i = 0; i < 4; i++) begin
         busy <= i[0];
         axr(A_VS, d, r);
         chk("vlan_sts", d, {31'h0, i[0]});
      end
      axw(16'h6000, 32'h1, 4'hF, r);
      chk("bresp", r, sidc_pkg::RESP_SLVERR);
      axr(16'h6000, d, r);
      chk("rresp", r, sidc_pkg::RESP_SLVERR);
      for (i = 0; i < 64; i++) begin
         pr[i] = 3'($urandom);
         axw(A_WD, {29'h0, pr[i]}, 4'hF, r);
         axw(A_CMD, 32'(i), 4'hF, r);
         chk("pending", pend, 1'b1);
         poll();
      end
      for (i = 63; i >= 0; i--) begin
         axw(A_CMD, 32'h80 | 32'(i), 4'hF, r);
         poll();
         axr(A_RD, d, r);
         chk("rd_data", d, {29'h0, pr[i]});
         lidx <= 6'(i);
         repeat (2) @(posedge clk);
         chk("lookup", lpri, pr[i]);
      end
      axw(A_RD, 32'h0, 4'hF, r);
      axr(A_RD, d, r);
      chk("rd_ro", d, {29'h0, pr[0]});
      axr(A_CMD, d, r);
      chk("cmd_rd", d, 32'h80);
      summarize();
   end
endmodule : tb
